// >>> src/sot_pkg.sv
// Constants and types for the SDH transmit overhead and test pattern framer.
// What this block does
// (R1) Every first framing byte is f6, every second framing byte is 28.
// (R2) Regenerator parity byte is a computed BIP-8, never set by software.
// (R3) Multiplex parity bytes are a computed BIP-Nx24, never set by software.
// (R4) The three pointer bytes come from pointer logic, not from overhead settings.
// (R5) K1 and K2 bits 1-5 carry protection signalling; K2 bits 6-8 carry MS-RDI.
// (R6) M0 and M1 carry the multiplex section remote error count.
// (R7) For STM-4/16/64 one configured column is copied into every interleaved column.
// (R8) Section and path traces are padded with a configurable idle character.
// (R9) Path parity byte is a computed BIP-8, never set by software.
// (R10) G1: REI bits 1-4, RDI bit 5, bits 6-7 reserved, bit 8 spare.
// (R11) V5: BIP-2, REI, RFI, signal label bits 5-7, RDI bit 8.
// (R12) K3: protection bits 1-4, spare bits 5-6, data link bits 7-8.
// (R13) K4: extended label, concatenation, protection 3-4, reserved 5-7, link bit 8.
// (R14) User payload patterns repeat every 32 or 2048 bits.
// (R15) Pseudo-random sequences of order 9 to 31 with optional output inversion.
// (R16) All-zeros, all-ones, 1:1, 1:3, 1:7 and 2-in-8 fixed patterns.
// (R17) Standard default loads inverted PRBS23 for VC-4 containers, else inverted PRBS15.
// (R18) Tandem monitoring is off, N1 of VC-4/VC-3, or N2, matching the structure.
// (R19) Port 2 transmitter may mirror port 1 continuously; port 1 never mirrors.
// (R20) Receiver expectation mirrors its transmitter or port 1 receiver; default independent.
// (R21) Transmit clock is internal, external or recovered from the received line.
// (R22) Parity bytes cover the proper span of the previous frame.
// (R23) Pseudo-random sequences use the standard generator polynomials.
`default_nettype none
package sot_pkg;
	localparam logic [7:0] A1_VAL = 8'hf6;
	localparam logic [7:0] A2_VAL = 8'h28;
	localparam logic [7:0] H1_VAL = 8'h6a;
	localparam logic [7:0] H2_VAL = 8'h0a;
	localparam logic [7:0] H1_CAT = 8'h93;
	localparam logic [7:0] H2_CAT = 8'hff;
	localparam logic [7:0] H3_VAL = 8'h00;
	localparam logic [7:0] G1_MASK = 8'hf9;
	localparam logic [7:0] K4_MASK = 8'hf1;
	localparam logic [6:0] SCR_SEED = 7'h7f;
	localparam logic [30:0] PRBS_SEED = 31'h7fffffff;
	localparam int ROWS = 9;
	localparam int SOH_COLS = 9;
	localparam int COLS_STM1 = 270;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_SOH1 = 8'h04;
	localparam logic [7:0] OFF_SOH2 = 8'h08;
	localparam logic [7:0] OFF_POH1 = 8'h0c;
	localparam logic [7:0] OFF_POH2 = 8'h10;
	localparam logic [7:0] OFF_LOPOH = 8'h14;
	localparam logic [7:0] OFF_TRC = 8'h18;
	localparam logic [7:0] OFF_TRCWR = 8'h1c;
	localparam logic [7:0] OFF_UPAT = 8'h20;
	localparam logic [7:0] OFF_UPADR = 8'h24;
	localparam logic [7:0] OFF_STAT = 8'h28;
	localparam logic [7:0] OFF_RXCFG = 8'h2c;
	localparam int CTRL_PAT = 0;
	localparam int CTRL_INV = 4;
	localparam int CTRL_ITU = 5;
	localparam int CTRL_CONT = 6;
	localparam int CTRL_TCM = 9;
	localparam int CTRL_CLK = 11;
	localparam int CTRL_FOLLOW = 13;
	localparam int RXC_SEL = 16;
	localparam int TRC_J0LEN = 8;
	localparam int TRC_J1LEN = 16;
	localparam int TRW_J1 = 15;
	localparam logic [31:0] CTRL_RST = 32'h0000_0016;
	localparam logic [31:0] TRC_RST = 32'h0000_0020;
	localparam logic [7:0] PAT_ALT1 = 8'h55;
	localparam logic [7:0] PAT_ALT3 = 8'h88;
	localparam logic [7:0] PAT_ALT7 = 8'h80;
	localparam logic [7:0] PAT_2IN8 = 8'h42;
	typedef enum logic [3:0] {P_U32 = 4'h0, P_U2K = 4'h1, P_9 = 4'h2, P_11 = 4'h3, P_15 = 4'h4,
		P_20 = 4'h5, P_23 = 4'h6, P_31 = 4'h7, P_ZERO = 4'h8, P_ONE = 4'h9, P_A1 = 4'ha,
		P_A3 = 4'hb, P_A7 = 4'hc, P_2IN8 = 4'hd} sot_pat_e;
	typedef enum logic [2:0] {C_C4 = 3'h0, C_C3VC4 = 3'h1, C_C3VC3 = 3'h2, C_C12 = 3'h3,
		C_C11 = 3'h4} sot_cont_e;
	typedef enum logic [1:0] {TCM_OFF = 2'h0, TCM_N1VC4 = 2'h1, TCM_N1VC3 = 2'h2,
		TCM_N2 = 2'h3} sot_tcm_e;
	typedef enum logic [1:0] {CLK_INT = 2'h0, CLK_EXT = 2'h1, CLK_RCV = 2'h2} sot_clk_e;
	typedef enum logic [1:0] {RXF_NONE = 2'h0, RXF_TX = 2'h1, RXF_P1 = 2'h2} sot_rxf_e;
endpackage
`default_nettype wire

// >>> src/sot_framer.sv
// SDH transmit framer: overhead insertion, parity bytes and bulk test pattern.
//
// The AHB-Lite interface to the registers and the register addresses are this design's own decisions.
`default_nettype none
module sot_framer
	import sot_pkg::*;
#(
	parameter int N = 1,
	parameter int PORT_ID = 1
)
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Settings shared with the other port
	input wire logic [31:0] p1_tx_cfg,
	input wire logic [31:0] p1_rx_cfg,
	output logic [31:0] tx_cfg_o,
	output logic [31:0] rx_cfg_o,
	// Line side
	output logic [7:0] tx_data,
	output logic tx_sof,
	output logic [1:0] tx_clk_sel,
	output logic [1:0] tcm_sel,
	output logic [7:0] lo_v5,
	output logic [7:0] lo_k4
);
	localparam int NCOL = COLS_STM1 * N;
	localparam int CW = $clog2(NCOL);
	localparam int NB2 = 3 * N;
	localparam int MW = $clog2(NB2);
	localparam int SW = $clog2(N) + 1;

	generate
		if (!(N == 1 || N == 4 || N == 16 || N == 64))
		begin : g_bad_n
			$error("N must be 1, 4, 16 or 64");
		end
	endgenerate

	function automatic logic [38:0] prbs8(input logic [30:0] s, input sot_pat_e p);
		logic [30:0] st;
		logic [7:0] o;
		logic fb;
		st = s;
		o = 8'h00;
		for (int i = 0; i < 8; i++)
		begin
			case (p)
				P_9: fb = st[8] ^ st[4];
				P_11: fb = st[10] ^ st[8];
				P_15: fb = st[14] ^ st[13];
				P_20: fb = st[19] ^ st[2];
				P_23: fb = st[22] ^ st[17];
				default: fb = st[30] ^ st[27];
			endcase
			st = {st[29:0], fb};
			o = {o[6:0], fb};
		end
		return {o, st};
	endfunction

	function automatic logic [14:0] scr8(input logic [6:0] s);
		logic [6:0] st;
		logic [7:0] o;
		st = s;
		o = 8'h00;
		for (int i = 0; i < 8; i++)
		begin
			o = {o[6:0], st[6]};
			st = {st[5:0], st[6] ^ st[5]};
		end
		return {o, st};
	endfunction

	function automatic logic [1:0] bip2_of(input logic [7:0] b);
		return {^{b[7], b[5], b[3], b[1]}, ^{b[6], b[4], b[2], b[0]}};
	endfunction

	function automatic logic [31:0] ctrl_fix(input logic [31:0] w);
		logic [31:0] v;
		logic vc4;
		v = w;
		case (v[CTRL_TCM +: 2])
			TCM_N1VC4: if (v[CTRL_CONT +: 3] != C_C4 && v[CTRL_CONT +: 3] != C_C3VC4)
				v[CTRL_CONT +: 3] = C_C4;
			TCM_N1VC3: v[CTRL_CONT +: 3] = C_C3VC3;
			TCM_N2: if (v[CTRL_CONT +: 3] != C_C12 && v[CTRL_CONT +: 3] != C_C11)
				v[CTRL_CONT +: 3] = C_C12;
			default: v = v;
		endcase
		vc4 = v[CTRL_CONT +: 3] == C_C4 || v[CTRL_CONT +: 3] == C_C3VC4;
		if (v[CTRL_ITU])
		begin
			v[CTRL_PAT +: 4] = vc4 ? P_23 : P_15; // R17
			v[CTRL_INV] = 1'b1; // R17
		end
		v[CTRL_ITU] = 1'b0;
		if (PORT_ID == 1)
			v[CTRL_FOLLOW] = 1'b0; // R19
		return v;
	endfunction

	logic [31:0] ctrl_r, soh1_r, soh2_r, poh1_r, poh2_r, lopoh_r, trc_r, rx_r, eff_ctrl;
	logic [3:0] row_r, gcol_r;
	logic [CW-1:0] col_r;
	logic [SW-1:0] sub_r;
	logic [MW-1:0] m3_r;
	logic in_soh, poh, isp, col_last, eof, scr_on;
	logic [7:0] raw_c, line_c, pat_byte, j0_c, j1_c, b1_acc_r, b1_prev_r, b3_acc_r, b3_prev_r;
	logic [7:0] b2_acc_r [NB2];
	logic [7:0] b2_prev_r [NB2];
	logic [1:0] bip2_acc_r, bip2_prev_r;
	logic [6:0] scr_r;
	logic [14:0] scr_c;
	logic [30:0] prbs_r;
	logic [38:0] pr_c;
	logic [10:0] ubit_r;
	logic [31:0] uw_c;
	logic [31:0] upat_mem [64];
	logic [5:0] upadr_r;
	logic [7:0] j0_mem [16];
	logic [7:0] j1_mem [64];
	logic [3:0] j0_idx_r;
	logic [5:0] j1_idx_r;
	logic [15:0] fcnt_r;
	logic [7:0] ap_addr_r;
	logic wr_r, rd1_r;
	logic [31:0] rd_c;
	sot_pat_e pat_c;

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// Mirroring port 1 is decided live, so its later changes follow through.
	assign eff_ctrl = (PORT_ID != 1 && ctrl_r[CTRL_FOLLOW]) ? p1_tx_cfg : ctrl_r; // R19
	assign pat_c = sot_pat_e'(eff_ctrl[CTRL_PAT +: 4]);
	assign in_soh = gcol_r < 4'd9;
	assign poh = col_r == CW'(SOH_COLS * N);
	assign isp = !in_soh && !poh;
	assign col_last = col_r == CW'(NCOL - 1);
	assign eof = row_r == 4'(ROWS - 1) && col_last;
	assign scr_on = !(row_r == 4'd0 && in_soh);
	assign scr_c = scr8(scr_r);
	assign line_c = raw_c ^ (scr_on ? scr_c[14:7] : 8'h00);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			row_r <= 4'd0;
			col_r <= '0;
			gcol_r <= 4'd0;
			sub_r <= '0;
			m3_r <= '0;
		end
		else if (col_last)
		begin
			col_r <= '0;
			gcol_r <= 4'd0;
			sub_r <= '0;
			m3_r <= '0;
			row_r <= (row_r == 4'(ROWS - 1)) ? 4'd0 : row_r + 4'd1;
		end
		else
		begin
			col_r <= col_r + CW'(1);
			m3_r <= (m3_r == MW'(NB2 - 1)) ? '0 : m3_r + MW'(1);
			if (in_soh)
			begin
				if (sub_r == SW'(N - 1))
				begin
					sub_r <= '0;
					gcol_r <= gcol_r + 4'd1;
				end
				else
					sub_r <= sub_r + SW'(1);
			end
		end
	end

	// Overhead bytes depend only on row and column group, except B1, H1, H2 and B2, which also depend on the sub-column.
	always_comb
	begin
		raw_c = 8'h00;
		if (in_soh)
		begin
			case (row_r)
				4'd0: raw_c = (gcol_r < 4'd3) ? A1_VAL : (gcol_r < 4'd6) ? A2_VAL : // R1
					(gcol_r == 4'd6) ? j0_c : 8'h00; // R7
				4'd1: if (gcol_r == 4'd0 && sub_r == '0)
						raw_c = b1_prev_r; // R2
					else if (gcol_r == 4'd3)
						raw_c = soh1_r[15:8];
					else if (gcol_r == 4'd6)
						raw_c = soh1_r[23:16];
				4'd3: if (gcol_r < 4'd3)
						raw_c = (sub_r == '0) ? H1_VAL : H1_CAT; // R4
					else if (gcol_r < 4'd6)
						raw_c = (sub_r == '0) ? H2_VAL : H2_CAT; // R4
					else
						raw_c = H3_VAL; // R4
				4'd4: if (gcol_r < 4'd3)
						raw_c = b2_prev_r[m3_r]; // R3
					else if (gcol_r == 4'd3)
						raw_c = soh2_r[7:0]; // R5
					else if (gcol_r == 4'd6)
						raw_c = soh2_r[15:8]; // R5
				4'd8: if (gcol_r == 4'd0)
						raw_c = soh1_r[7:0];
					else if (gcol_r == 4'd4)
						raw_c = soh2_r[31:24]; // R6
					else if (gcol_r == 4'd5)
						raw_c = soh2_r[23:16]; // R6
					else if (gcol_r == 4'd6)
						raw_c = soh1_r[31:24];
				default: raw_c = 8'h00;
			endcase
		end
		else if (poh)
		begin
			case (row_r)
				4'd0: raw_c = j1_c;
				4'd1: raw_c = b3_prev_r; // R9
				4'd2: raw_c = poh1_r[7:0];
				4'd3: raw_c = poh1_r[15:8] & G1_MASK; // R10
				4'd4: raw_c = poh1_r[23:16];
				4'd5: raw_c = poh1_r[31:24];
				4'd6: raw_c = poh2_r[23:16];
				4'd7: raw_c = poh2_r[7:0]; // R12
				default: raw_c = poh2_r[15:8];
			endcase
		end
		else
			raw_c = pat_byte;
	end

	assign j0_c = ({1'b0, j0_idx_r} < trc_r[TRC_J0LEN +: 5]) ? j0_mem[j0_idx_r] : trc_r[7:0]; // R8
	assign j1_c = ({1'b0, j1_idx_r} < trc_r[TRC_J1LEN +: 7]) ? j1_mem[j1_idx_r] : trc_r[7:0]; // R8

	assign pr_c = prbs8(prbs_r, pat_c);
	assign uw_c = (pat_c == P_U2K) ? upat_mem[ubit_r[10:5]] : upat_mem[0];
	always_comb
	begin
		case (pat_c)
			P_U32, P_U2K: pat_byte = uw_c[5'd31 - {ubit_r[4:3], 3'b000} -: 8]; // R14
			P_ZERO: pat_byte = 8'h00; // R16
			P_ONE: pat_byte = 8'hff; // R16
			P_A1: pat_byte = PAT_ALT1; // R16
			P_A3: pat_byte = PAT_ALT3; // R16
			P_A7: pat_byte = PAT_ALT7; // R16
			P_2IN8: pat_byte = PAT_2IN8; // R16
			default: pat_byte = pr_c[38:31] ^ {8{eff_ctrl[CTRL_INV]}}; // R15
		endcase
	end

	// The low bits of each generator run as a maximal sequence from all ones.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			prbs_r <= PRBS_SEED;
			ubit_r <= 11'd0;
		end
		else if (isp)
		begin
			ubit_r <= ubit_r + 11'd8; // R14
			prbs_r <= pr_c[30:0]; // R23
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			scr_r <= SCR_SEED;
		else if (row_r == 4'd0 && gcol_r == 4'd8 && sub_r == SW'(N - 1))
			scr_r <= SCR_SEED;
		else if (scr_on)
			scr_r <= scr_c[6:0];
	end

	// B1 runs over the scrambled line, B2, B3 and BIP-2 over unscrambled bytes.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			b1_acc_r <= 8'h00;
			b1_prev_r <= 8'h00;
			b3_acc_r <= 8'h00;
			b3_prev_r <= 8'h00;
			bip2_acc_r <= 2'b00;
			bip2_prev_r <= 2'b00;
			fcnt_r <= 16'h0000;
		end
		else if (eof)
		begin
			b1_prev_r <= b1_acc_r ^ line_c; // R22
			b1_acc_r <= 8'h00;
			b3_prev_r <= b3_acc_r ^ raw_c; // R22
			b3_acc_r <= 8'h00;
			bip2_prev_r <= bip2_acc_r ^ bip2_of(raw_c);
			bip2_acc_r <= 2'b00;
			fcnt_r <= fcnt_r + 16'h0001;
		end
		else
		begin
			b1_acc_r <= b1_acc_r ^ line_c; // R2
			if (!in_soh)
				b3_acc_r <= b3_acc_r ^ raw_c; // R9
			if (isp)
				bip2_acc_r <= bip2_acc_r ^ bip2_of(raw_c); // R11
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			for (int k = 0; k < NB2; k++)
			begin
				b2_acc_r[k] <= 8'h00;
				b2_prev_r[k] <= 8'h00;
			end
		end
		else
		begin
			for (int k = 0; k < NB2; k++)
			begin
				if (eof)
				begin
					b2_prev_r[k] <= b2_acc_r[k] ^ ((MW'(k) == m3_r) ? raw_c : 8'h00); // R3
					b2_acc_r[k] <= 8'h00;
				end
				else if (MW'(k) == m3_r && !(row_r < 4'd3 && in_soh))
					b2_acc_r[k] <= b2_acc_r[k] ^ raw_c; // R3
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			j0_idx_r <= 4'd0;
			j1_idx_r <= 6'd0;
		end
		else if (eof)
		begin
			j0_idx_r <= j0_idx_r + 4'd1;
			j1_idx_r <= j1_idx_r + 6'd1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			tx_data <= 8'h00;
			tx_sof <= 1'b0;
			tx_cfg_o <= 32'h0;
			rx_cfg_o <= 32'h0;
			tx_clk_sel <= CLK_INT;
			tcm_sel <= TCM_OFF;
			lo_v5 <= 8'h00;
			lo_k4 <= 8'h00;
		end
		else
		begin
			tx_data <= line_c;
			tx_sof <= row_r == 4'd0 && col_r == '0;
			tx_cfg_o <= eff_ctrl;
			tx_clk_sel <= eff_ctrl[CTRL_CLK +: 2]; // R21
			tcm_sel <= eff_ctrl[CTRL_TCM +: 2]; // R18
			lo_v5 <= {bip2_prev_r, lopoh_r[5:0]}; // R11
			lo_k4 <= lopoh_r[15:8] & K4_MASK; // R13
			if (rx_r[RXC_SEL +: 2] == RXF_TX)
				rx_cfg_o <= eff_ctrl; // R20
			else if (rx_r[RXC_SEL +: 2] == RXF_P1 && PORT_ID != 1)
				rx_cfg_o <= p1_rx_cfg; // R20
			else
				rx_cfg_o <= rx_r;
		end
	end

	// Reads take one wait state so a write just before is always visible.
	assign hreadyout = !rd1_r;
	assign hresp = 1'b0;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ap_addr_r <= 8'h00;
			wr_r <= 1'b0;
			rd1_r <= 1'b0;
			hrdata <= 32'h0;
		end
		else
		begin
			rd1_r <= 1'b0;
			if (rd1_r)
				hrdata <= rd_c;
			if (hsel && hready && htrans[1])
			begin
				ap_addr_r <= haddr[7:0];
				wr_r <= hwrite;
				rd1_r <= !hwrite;
			end
			else if (hready)
				wr_r <= 1'b0;
		end
	end

	always_comb
	begin
		if (ap_addr_r == OFF_CTRL)
			rd_c = ctrl_r;
		else if (ap_addr_r == OFF_SOH1)
			rd_c = soh1_r;
		else if (ap_addr_r == OFF_SOH2)
			rd_c = soh2_r;
		else if (ap_addr_r == OFF_POH1)
			rd_c = poh1_r;
		else if (ap_addr_r == OFF_POH2)
			rd_c = poh2_r;
		else if (ap_addr_r == OFF_LOPOH)
			rd_c = lopoh_r;
		else if (ap_addr_r == OFF_TRC)
			rd_c = trc_r;
		else if (ap_addr_r == OFF_UPAT)
			rd_c = upat_mem[upadr_r];
		else if (ap_addr_r == OFF_UPADR)
			rd_c = {26'h0, upadr_r};
		else if (ap_addr_r == OFF_STAT)
			rd_c = {b3_prev_r, b1_prev_r, fcnt_r};
		else if (ap_addr_r == OFF_RXCFG)
			rd_c = rx_r;
		else
			rd_c = 32'h0;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ctrl_r <= CTRL_RST;
			soh1_r <= 32'h0;
			soh2_r <= 32'h0;
			poh1_r <= 32'h0;
			poh2_r <= 32'h0;
			lopoh_r <= 32'h0;
			trc_r <= TRC_RST;
			rx_r <= 32'h0;
			upadr_r <= 6'd0;
		end
		else if (wr_r)
		begin
			if (ap_addr_r == OFF_CTRL)
				ctrl_r <= ctrl_fix(hwdata); // R18
			else if (ap_addr_r == OFF_SOH1)
				soh1_r <= hwdata;
			else if (ap_addr_r == OFF_SOH2)
				soh2_r <= hwdata;
			else if (ap_addr_r == OFF_POH1)
				poh1_r <= hwdata;
			else if (ap_addr_r == OFF_POH2)
				poh2_r <= hwdata;
			else if (ap_addr_r == OFF_LOPOH)
				lopoh_r <= {16'h0, hwdata[15:8], 2'b00, hwdata[5:0]};
			else if (ap_addr_r == OFF_TRC)
				trc_r <= {9'h0, hwdata[22:16], 3'h0, hwdata[12:0]};
			else if (ap_addr_r == OFF_UPAT)
				upadr_r <= upadr_r + 6'd1;
			else if (ap_addr_r == OFF_UPADR)
				upadr_r <= hwdata[5:0];
			else if (ap_addr_r == OFF_RXCFG)
			begin
				rx_r <= hwdata;
				if (PORT_ID == 1 && hwdata[RXC_SEL +: 2] == RXF_P1)
					rx_r[RXC_SEL +: 2] <= RXF_NONE; // R20
			end
		end
	end

	always_ff @(posedge hclk)
	begin
		if (wr_r && ap_addr_r == OFF_UPAT)
			upat_mem[upadr_r] <= hwdata;
		if (wr_r && ap_addr_r == OFF_TRCWR && !hwdata[TRW_J1])
			j0_mem[hwdata[11:8]] <= hwdata[7:0];
		if (wr_r && ap_addr_r == OFF_TRCWR && hwdata[TRW_J1])
			j1_mem[hwdata[13:8]] <= hwdata[7:0];
	end

	frame_a1_a: assert property (tx_sof |-> tx_data == A1_VAL) else $error("A1 missing"); // R1
	frame_a2_a: assert property (row_r == 4'd0 && gcol_r == 4'd3 // R1
		|=> tx_data == A2_VAL) else $error("A2 missing");
	b1_calc_a: assert property (eof |=> b1_prev_r == $past(b1_acc_r ^ line_c)) // R2
		else $error("B1 not latched");
	b2_place_a: assert property (row_r == 4'd4 && gcol_r < 4'd3 // R3
		|-> raw_c == b2_prev_r[m3_r]) else $error("B2 not placed");
	ptr_fixed_a: assert property (row_r == 4'd3 && gcol_r == 4'd0 && sub_r == '0 // R4
		|-> raw_c == H1_VAL) else $error("H1 wrong");
	b3_place_a: assert property (poh && row_r == 4'd1 // R9
		|-> ##1 tx_data == $past(line_c) && $past(raw_c) == $past(b3_prev_r))
		else $error("B3 not placed");
	trace_pad_a: assert property (poh && row_r == 4'd0 // R8
		&& {1'b0, j1_idx_r} >= trc_r[TRC_J1LEN +: 7] |-> raw_c == trc_r[7:0])
		else $error("J1 pad wrong");
	ubit_step_a: assert property (isp && !eof |=> ubit_r == $past(ubit_r) + 11'd8) // R14
		else $error("Pattern step wrong");
	no_follow_a: assert property (PORT_ID != 1 || !ctrl_r[CTRL_FOLLOW]) // R19
		else $error("Port 1 mirrors");
endmodule
`default_nettype wire

// >>> bench/sot_line_rx.sv
// Line-side model of the equipment under test: aligns, descrambles and records frame bytes.
`default_nettype none
module sot_line_rx
	import sot_pkg::*;
#(
	parameter int N = 1
)
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Line from the framer
	input wire logic [7:0] tx_data,
	input wire logic tx_sof
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int W = COLS_STM1 * N;
	logic [7:0] oh [9][9];
	logic [7:0] pay_byte;
	logic [7:0] b1_exp;
	logic [7:0] b1_ref;
	logic [7:0] b1_got;
	logic [7:0] acc = 8'h00;
	logic [6:0] s = SCR_SEED;
	int p = 0;
	int frames = 0;
	int frame_len = 0;

	// Parity is summed over the bytes as sent, so it is taken before descrambling.
	always @(posedge hclk)
	begin : rx_proc
		int r;
		int c;
		logic [7:0] d;
		if (!hresetn)
			frames = 0;
		if (tx_sof === 1'b1)
		begin
			frame_len = p + 1;
			b1_exp = acc;
			acc = 8'h00;
			p = 0;
			frames++;
		end
		else
			p++;
		r = p / W;
		c = p % W;
		if (r == 0 && c == 9 * N)
			s = SCR_SEED;
		d = tx_data;
		if (r > 0 || c >= 9 * N)
		begin
			for (int i = 7; i >= 0; i--)
			begin
				d[i] = d[i] ^ s[6];
				s = {s[5:0], s[6] ^ s[5]};
			end
		end
		acc = acc ^ tx_data;
		if (r < 9 && c < 9)
			oh[r][c] = d;
		if (r == 1 && c == 0)
		begin
			b1_got = d;
			b1_ref = b1_exp;
		end
		if (r == 4 && c == 100)
			pay_byte = d;
	end
endmodule
`default_nettype wire

// >>> bench/sot_framer_tb.sv
// Self-checking testbench for the transmit framer, driven over AHB-Lite.
`default_nettype none
module sot_framer_tb
	import sot_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LIMIT = 70000;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] p1_tx_cfg = 32'h0;
	logic [31:0] p1_rx_cfg = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic [31:0] tx_cfg_o;
	logic [31:0] rx_cfg_o;
	logic [7:0] tx_data;
	logic tx_sof;
	logic [1:0] tx_clk_sel;
	logic [1:0] tcm_sel;
	logic [7:0] lo_v5;
	logic [7:0] lo_k4;
	int n_errors = 0;
	int cmp_count = 0;
	int cyc = 0;

	always #5 hclk = ~hclk;

	// Port 2 so that the mirroring paths are reachable at all.
	sot_framer #(.N(1), .PORT_ID(2)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.p1_tx_cfg(p1_tx_cfg), .p1_rx_cfg(p1_rx_cfg), .tx_cfg_o(tx_cfg_o),
		.rx_cfg_o(rx_cfg_o), .tx_data(tx_data), .tx_sof(tx_sof), .tx_clk_sel(tx_clk_sel),
		.tcm_sel(tcm_sel), .lo_v5(lo_v5), .lo_k4(lo_k4));

	sot_line_rx #(.N(1)) rx (.hclk(hclk), .hresetn(hresetn), .tx_data(tx_data),
		.tx_sof(tx_sof));

	task automatic tally_and_finish;
		$display("errors %0d comparisons %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	always @(posedge hclk)
	begin
		cyc++;
		if (cyc == LIMIT)
		begin
			n_errors++;
			$display("unexpected at %0t: run did not end in time", $time);
			tally_and_finish();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		cmp_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
		end
	endtask

	// The master waits on hready with no fixed latency; only the run limit ends a wait.
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wr ? d : 32'h0;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		bus(1'b0, a, 32'h0, q);
	endtask

	task automatic settle(input int k);
		int f0;
		f0 = rx.frames;
		while (rx.frames < f0 + k)
			@(posedge hclk);
		repeat (10) @(posedge hclk);
	endtask

	task automatic t_reset;
		logic [31:0] q;
		rd(OFF_CTRL, q);
		chk(q, CTRL_RST, "control after reset");
		rd(OFF_TRC, q);
		chk(q, TRC_RST, "trace setup after reset");
		rd(8'h30, q);
		chk(q, 32'h0, "unmapped read");
		chk(32'(hresp), 32'h0, "okay response");
		chk(tx_cfg_o, CTRL_RST, "independent by default");
	endtask

	// Pointer bytes H1 and H2 and the B1 parity byte must survive an attempt to fill the first section overhead register with ones.
	task automatic t_frame;
		wr(OFF_SOH1, 32'hffff_ffff);
		wr(OFF_SOH2, 32'h1122_3344);
		wr(OFF_TRC, 32'h0000_002a);
		settle(3);
		for (int i = 0; i < 3; i++)
		begin
			chk(32'(rx.oh[0][i]), 32'(A1_VAL), "first framing");
			chk(32'(rx.oh[0][i + 3]), 32'(A2_VAL), "second framing");
		end
		chk(32'(rx.frame_len), 32'(ROWS * COLS_STM1), "frame length");
		chk(32'(rx.b1_got), 32'(rx.b1_ref), "section parity");
		chk(32'(rx.oh[3][0]), 32'(H1_VAL), "pointer first");
		chk(32'(rx.oh[3][3]), 32'(H2_VAL), "pointer second");
		chk(32'(rx.oh[4][3]), 32'h44, "first switching byte");
		chk(32'(rx.oh[4][6]), 32'h33, "second switching byte");
		chk(32'(rx.oh[8][4]), 32'h11, "error count high");
		chk(32'(rx.oh[8][5]), 32'h22, "error count low");
		chk(32'(rx.oh[0][6]), 32'h2a, "trace idle fill");
	endtask

	task automatic t_std;
		logic [31:0] q;
		logic [31:0] e;
		for (int c = 0; c < 5; c++)
		begin
			wr(OFF_CTRL, {23'h0, 3'(c), 6'h20});
			rd(OFF_CTRL, q);
			e = {23'h0, 3'(c), 2'b01, (c < 2) ? P_23 : P_15};
			chk(q, e, "standard default");
			chk(tx_cfg_o, e, "own settings used");
		end
	endtask

	task automatic t_tcm;
		logic [31:0] q;
		logic [2:0] ct [4] = '{3'h0, 3'h0, 3'h2, 3'h3};
		// The pattern memory is not reset, so word 0 needs a value before user32 is selected.
		wr(OFF_UPADR, 32'h0);
		wr(OFF_UPAT, 32'h5a5a_5a5a);
		for (int i = 0; i < 4; i++)
		begin
			wr(OFF_CTRL, {19'h0, 2'(i % 3), 2'(i), 9'h0});
			rd(OFF_CTRL, q);
			chk(32'(q[8:6]), 32'(ct[i]), "structure follows tcm");
			chk(32'(tcm_sel), 32'(i), "tcm select");
			chk(32'(tx_clk_sel), 32'(i % 3), "clock select");
		end
	endtask

	task automatic t_follow;
		p1_tx_cfg <= 32'h0000_1a89;
		p1_rx_cfg <= 32'h0000_6c55;
		wr(OFF_CTRL, 32'h0000_2000);
		repeat (3) @(posedge hclk);
		chk(tx_cfg_o, 32'h0000_1a89, "mirror port 1");
		wr(OFF_RXCFG, 32'h0001_0000);
		repeat (3) @(posedge hclk);
		chk(rx_cfg_o, 32'h0000_1a89, "receiver follows tx");
		wr(OFF_RXCFG, 32'h0002_0000);
		repeat (3) @(posedge hclk);
		chk(rx_cfg_o, 32'h0000_6c55, "receiver follows port 1");
		p1_tx_cfg <= 32'h0000_0004;
		repeat (3) @(posedge hclk);
		chk(tx_cfg_o, 32'h0000_0004, "mirror keeps tracking");
		wr(OFF_CTRL, 32'h0);
		wr(OFF_RXCFG, 32'h0);
		repeat (3) @(posedge hclk);
		chk(tx_cfg_o, 32'h0, "mirror released");
	endtask

	task automatic t_lopoh;
		wr(OFF_LOPOH, 32'h0000_ff3f);
		repeat (2) @(posedge hclk);
		chk(32'(lo_k4), 32'hf1, "low order k4 fields");
		chk(32'(lo_v5[5:0]), 32'h3f, "low order v5 fields");
	endtask

	task automatic t_pat;
		sot_pat_e p [6] = '{P_ZERO, P_ONE, P_A1, P_A3, P_A7, P_2IN8};
		logic [7:0] e [6] = '{8'h00, 8'hff, 8'h55, 8'h88, 8'h80, 8'h42};
		for (int i = 0; i < 6; i++)
		begin
			wr(OFF_CTRL, {28'h0, p[i]});
			settle(2);
			chk(32'(rx.pay_byte), 32'(e[i]), "fixed payload");
		end
		wr(OFF_CTRL, 32'h0);
		settle(2);
		chk(32'(rx.pay_byte), 32'h5a, "user payload");
	endtask

	initial
	begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_frame();
		t_std();
		t_tcm();
		t_follow();
		t_lopoh();
		t_pat();
		tally_and_finish();
	end
endmodule
`default_nettype wire
